/* File: shared/pwm_config_map.svh */
`ifndef PWM_CONFIG_MAP_SVH
`define PWM_CONFIG_MAP_SVH

// Addressing byte: fixed device code in the top four bits.
`define TW_DEVICE_CODE 4'h5
`define TW_CODE_MSB 7
`define TW_CODE_LSB 4
`define TW_SEL_MSB 3
`define TW_SEL_LSB 1
`define TW_RW_BIT 0
`define TW_RW_READ 1'b1
`define TW_RW_WRITE 1'b0

// Configuration byte layout.
`define CFG_DUTY_MSB 4
`define CFG_DUTY_LSB 0
`define CFG_CMD_MSB 7
`define CFG_CMD_LSB 5
`define CFG_DUTY_RESET 5'h10

// Command codes in the top three bits of a written byte.
`define CFG_CMD_DUTY 3'h0
`define CFG_CMD_FULL_ON 3'h1
`define CFG_CMD_RECALL 3'h2
`define CFG_CMD_SHUTDOWN 3'h4

// Core clock period and serial clock quarter period.
`define CORE_CLK_NS 10
`define TW_QUARTER_NS 40
`define PWM_DIV_DEFAULT 4

// Controller registers on APB.
`define CTL_REG_CTRL 12'h000
`define CTL_REG_STATUS 12'h004
`define CTRL_GO_BIT 0
`define CTRL_READ_BIT 1
`define CTRL_LAST_BIT 2
`define CTRL_SEL_MSB 6
`define CTRL_SEL_LSB 4
`define CTRL_DATA_MSB 15
`define CTRL_DATA_LSB 8
`define STAT_BUSY_BIT 0
`define STAT_NACK_BIT 1
`define STAT_OPEN_BIT 2
`define STAT_DATA_MSB 15
`define STAT_DATA_LSB 8

`endif

/* File: shared/pwm_config_pkg.sv */
package pwm_config_pkg;

  // Serial slave states, Gray coded along the receive and send paths.
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_ADDR = 3'h1,
    D_ADDR_ACK = 3'h3,
    D_RECV = 3'h2,
    D_DATA_ACK = 3'h6,
    D_SEND = 3'h7,
    D_MASTER_ACK = 3'h5
  } dev_state_e;

  // Bus controller states.
  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_BIT = 3'h3,
    M_HOLD = 3'h2,
    M_STOP = 3'h6
  } mst_state_e;

endpackage : pwm_config_pkg

/* File: shared/two_wire_if.sv */
`timescale 1ns/10ps
interface two_wire_if;
  logic scl_m_out;
  logic scl_m_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  wire scl;
  wire sda;

  // Open-drain wired-AND with pull-ups: a line is low while any driver pulls it low.
  assign scl = !(scl_m_oe && !scl_m_out);
  assign sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));

  modport master_end (
    output scl_m_out,
    output scl_m_oe,
    output sda_m_out,
    output sda_m_oe,
    input scl,
    input sda
  );

  modport device_end (
    output sda_s_out,
    output sda_s_oe,
    input scl,
    input sda
  );
endinterface : two_wire_if

/* File: hw/pwm_config_device.sv */
`timescale 1ns/10ps
`include "pwm_config_map.svh"
module pwm_config_device #(
  parameter logic [2:0] CMD_DUTY = `CFG_CMD_DUTY,
  parameter logic [2:0] CMD_FULL_ON = `CFG_CMD_FULL_ON,
  parameter logic [2:0] CMD_SHUTDOWN = `CFG_CMD_SHUTDOWN,
  parameter logic [2:0] CMD_RECALL = `CFG_CMD_RECALL,
  parameter int PWM_DIV = `PWM_DIV_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rstn,
  two_wire_if.device_end bus,
  input wire logic select_pin_bit0,
  input wire logic select_pin_bit1,
  input wire logic select_pin_bit2,
  output logic modulated_output,
  output logic modulated_output_oe,
  output logic [4:0] duty_value,
  output logic shutdown_active
);

  // Command codes must be distinct so each write is unambiguous.
  if (CMD_DUTY == CMD_FULL_ON || CMD_DUTY == CMD_SHUTDOWN || CMD_DUTY == CMD_RECALL ||
      CMD_FULL_ON == CMD_SHUTDOWN || CMD_FULL_ON == CMD_RECALL ||
      CMD_SHUTDOWN == CMD_RECALL) begin : g_bad_cmd
    $error("Command codes must be distinct.");
  end
  if (PWM_DIV < 1 || PWM_DIV > 255) begin : g_bad_div
    $error("PWM_DIV must be between 1 and 255.");
  end

  localparam logic [7:0] DIV_LAST = 8'(PWM_DIV - 1);

  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic [2:0] sel_meta_q;
  logic [2:0] sel_sync_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_in;

  // Bus lines and select pins pass two flip-flops; the third bit only finds edges.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      sel_meta_q <= 3'h0;
      sel_sync_q <= 3'h0;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], bus.scl};
      sda_sync_q <= {sda_sync_q[1:0], bus.sda};
      sel_meta_q <= {select_pin_bit2, select_pin_bit1, select_pin_bit0};
      sel_sync_q <= sel_meta_q;
    end
  end

  // Bus events: data edges while the clock is high mark START and STOP.
  assign sda_in = sda_sync_q[1];
  assign scl_rise = scl_sync_q[1] && !scl_sync_q[2];
  assign scl_fall = !scl_sync_q[1] && scl_sync_q[2];
  assign start_seen = scl_sync_q[1] && scl_sync_q[2] && !sda_sync_q[1] && sda_sync_q[2];
  assign stop_seen = scl_sync_q[1] && scl_sync_q[2] && sda_sync_q[1] && !sda_sync_q[2];

  pwm_config_pkg::dev_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic rw_q, rw_d;
  logic oe_q, oe_d;
  logic [4:0] duty_q, duty_d;
  logic shdn_q, shdn_d;
  logic full_q, full_d;
  logic [7:0] read_byte;
  logic [2:0] wr_cmd;

  // Read byte reports the active command state and the held duty value.
  always_comb begin
    if (shdn_q) begin
      read_byte = {CMD_SHUTDOWN, duty_q};
    end else if (full_q) begin
      read_byte = {CMD_FULL_ON, duty_q};
    end else begin
      read_byte = {CMD_DUTY, duty_q};
    end
  end

  assign wr_cmd = sh_q[`CFG_CMD_MSB:`CFG_CMD_LSB];

  // Serial protocol engine and configuration register next state.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rw_d = rw_q;
    oe_d = oe_q;
    duty_d = duty_q;
    shdn_d = shdn_q;
    full_d = full_q;
    unique case (st_q)
      pwm_config_pkg::D_IDLE: begin
      end
      pwm_config_pkg::D_ADDR: begin
        if (scl_rise) begin
          sh_d = {sh_q[6:0], sda_in};
          cnt_d = cnt_q + 4'h1;
        end else if (scl_fall && cnt_q == 4'h8) begin
          if (sh_q[`TW_CODE_MSB:`TW_CODE_LSB] == `TW_DEVICE_CODE &&
              sh_q[`TW_SEL_MSB:`TW_SEL_LSB] == sel_sync_q) begin
            st_d = pwm_config_pkg::D_ADDR_ACK;
            oe_d = 1'b1;
            rw_d = sh_q[`TW_RW_BIT];
          end else begin
            st_d = pwm_config_pkg::D_IDLE;
          end
        end
      end
      pwm_config_pkg::D_ADDR_ACK: begin
        if (scl_fall) begin
          cnt_d = 4'h0;
          if (rw_q == `TW_RW_READ) begin
            st_d = pwm_config_pkg::D_SEND;
            sh_d = read_byte;
            oe_d = !read_byte[7];
          end else begin
            st_d = pwm_config_pkg::D_RECV;
            oe_d = 1'b0;
          end
        end
      end
      pwm_config_pkg::D_RECV: begin
        if (scl_rise) begin
          sh_d = {sh_q[6:0], sda_in};
          cnt_d = cnt_q + 4'h1;
        end else if (scl_fall && cnt_q == 4'h8) begin
          st_d = pwm_config_pkg::D_DATA_ACK;
          oe_d = 1'b1;
          if (wr_cmd == CMD_DUTY) begin
            duty_d = sh_q[`CFG_DUTY_MSB:`CFG_DUTY_LSB];
            full_d = 1'b0;
          end else if (wr_cmd == CMD_FULL_ON) begin
            full_d = 1'b1;
          end else if (wr_cmd == CMD_SHUTDOWN) begin
            shdn_d = 1'b1;
          end else if (wr_cmd == CMD_RECALL) begin
            shdn_d = 1'b0;
          end
        end
      end
      pwm_config_pkg::D_DATA_ACK: begin
        if (scl_fall) begin
          st_d = pwm_config_pkg::D_RECV;
          cnt_d = 4'h0;
          oe_d = 1'b0;
        end
      end
      pwm_config_pkg::D_SEND: begin
        if (scl_fall) begin
          if (cnt_q == 4'h7) begin
            st_d = pwm_config_pkg::D_MASTER_ACK;
            oe_d = 1'b0;
          end else begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = !sh_q[6];
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      pwm_config_pkg::D_MASTER_ACK: begin
        if (scl_rise && sda_in) begin
          st_d = pwm_config_pkg::D_IDLE;
        end else if (scl_fall) begin
          st_d = pwm_config_pkg::D_SEND;
          sh_d = read_byte;
          oe_d = !read_byte[7];
          cnt_d = 4'h0;
        end
      end
      default: begin
        st_d = pwm_config_pkg::D_IDLE;
        oe_d = 1'b0;
      end
    endcase
    if (start_seen) begin
      st_d = pwm_config_pkg::D_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_seen) begin
      st_d = pwm_config_pkg::D_IDLE;
      oe_d = 1'b0;
    end
  end

  // Protocol and configuration registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= pwm_config_pkg::D_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      duty_q <= `CFG_DUTY_RESET;
      shdn_q <= 1'b0;
      full_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
      duty_q <= duty_d;
      shdn_q <= shdn_d;
      full_q <= full_d;
    end
  end

  // Open-drain data pin: only ever pulls low.
  assign bus.sda_s_out = 1'b0;
  assign bus.sda_s_oe = oe_q;

  logic [7:0] pre_q, pre_d;
  logic [4:0] phase_q, phase_d;
  logic pwm_q, pwm_d;
  logic pwm_oe_q, pwm_oe_d;

  // Thirty-two step modulator; the output is high while the phase is below the duty, or for the whole period under full-on.
  always_comb begin
    pre_d = (pre_q == DIV_LAST) ? 8'h00 : pre_q + 8'h01;
    phase_d = (pre_q == DIV_LAST) ? phase_q + 5'h01 : phase_q;
    pwm_d = full_q || (phase_q < duty_q);
    pwm_oe_d = !shdn_q;
  end

  // Modulator registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 8'h00;
      phase_q <= 5'h00;
      pwm_q <= 1'b0;
      pwm_oe_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      phase_q <= phase_d;
      pwm_q <= pwm_d;
      pwm_oe_q <= pwm_oe_d;
    end
  end

  assign modulated_output = pwm_q;
  assign modulated_output_oe = pwm_oe_q;
  assign duty_value = duty_q;
  assign shutdown_active = shdn_q;

endmodule : pwm_config_device

/* File: hw/pwm_config_master.sv */
`timescale 1ns/10ps
`include "pwm_config_map.svh"
module pwm_config_master #(
  parameter int QUARTER_NS = `TW_QUARTER_NS
) (
  input wire logic core_clk,
  input wire logic rstn,
  two_wire_if.master_end bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int QCYC = (QUARTER_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS;
  if (QCYC < 4 || QCYC > 255) begin : g_bad_q
    $error("Quarter period must give 4 to 255 core cycles.");
  end
  localparam logic [7:0] Q_LAST = 8'(QCYC - 1);

  logic [1:0] sda_sync_q;
  logic sda_in;

  // The data line passes two flip-flops before the engine samples it.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sda_sync_q <= 2'h3;
    end else begin
      sda_sync_q <= {sda_sync_q[0], bus.sda};
    end
  end
  assign sda_in = sda_sync_q[1];

  pwm_config_pkg::mst_state_e st_q, st_d;
  logic [7:0] qcnt_q, qcnt_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bitn_q, bitn_d;
  logic [8:0] tx_q, tx_d;
  logic [7:0] rx_q, rx_d;
  logic is_addr_q, is_addr_d;
  logic read_q, read_d;
  logic last_q, last_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic scl_oe_q, scl_oe_d;
  logic sda_oe_q, sda_oe_d;
  logic nack_q, nack_d;
  logic [7:0] rdata_q, rdata_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic tick;
  logic go;
  logic wr_ctrl;
  logic mapped;

  assign tick = (qcnt_q == Q_LAST);
  assign mapped = (paddr == `CTL_REG_CTRL) || (paddr == `CTL_REG_STATUS);
  assign wr_ctrl = psel && penable && pwrite && (paddr == `CTL_REG_CTRL);
  assign go = wr_ctrl && pwdata[`CTRL_GO_BIT];

  // Bus engine: each bit spends one quarter in each of four phases.
  always_comb begin
    st_d = st_q;
    qcnt_d = tick ? 8'h00 : qcnt_q + 8'h01;
    ph_d = ph_q;
    bitn_d = bitn_q;
    tx_d = tx_q;
    rx_d = rx_q;
    is_addr_d = is_addr_q;
    read_d = read_q;
    last_d = last_q;
    wbyte_d = wbyte_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    nack_d = nack_q;
    rdata_d = rdata_q;
    unique case (st_q)
      pwm_config_pkg::M_IDLE: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
        if (go) begin
          read_d = pwdata[`CTRL_READ_BIT];
          last_d = pwdata[`CTRL_LAST_BIT];
          wbyte_d = pwdata[`CTRL_DATA_MSB:`CTRL_DATA_LSB];
          tx_d = {`TW_DEVICE_CODE, pwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB],
                  pwdata[`CTRL_READ_BIT], 1'b1};
          is_addr_d = 1'b1;
          nack_d = 1'b0;
          st_d = pwm_config_pkg::M_START;
          ph_d = 2'h0;
          qcnt_d = 8'h00;
        end
      end
      pwm_config_pkg::M_START: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            sda_oe_d = 1'b1;
          end else if (ph_q == 2'h1) begin
            scl_oe_d = 1'b1;
          end else begin
            st_d = pwm_config_pkg::M_BIT;
            ph_d = 2'h0;
            bitn_d = 4'h0;
          end
        end
      end
      pwm_config_pkg::M_BIT: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            sda_oe_d = !tx_q[8];
          end else if (ph_q == 2'h1) begin
            scl_oe_d = 1'b0;
          end else if (ph_q == 2'h3) begin
            scl_oe_d = 1'b1;
            rx_d = {rx_q[6:0], sda_in};
            tx_d = {tx_q[7:0], 1'b1};
            bitn_d = bitn_q + 4'h1;
            if (bitn_q == 4'h8) begin
              bitn_d = 4'h0;
              if (is_addr_q) begin
                if (sda_in) begin
                  nack_d = 1'b1;
                  st_d = pwm_config_pkg::M_STOP;
                end else begin
                  is_addr_d = 1'b0;
                  tx_d = read_q ? {8'hff, last_q} : {wbyte_q, 1'b1};
                end
              end else begin
                rdata_d = rx_q;
                nack_d = !read_q && sda_in;
                st_d = (last_q || (!read_q && sda_in)) ? pwm_config_pkg::M_STOP :
                       pwm_config_pkg::M_HOLD;
              end
            end
          end
        end
      end
      pwm_config_pkg::M_HOLD: begin
        if (go) begin
          last_d = pwdata[`CTRL_LAST_BIT];
          tx_d = read_q ? {8'hff, pwdata[`CTRL_LAST_BIT]} :
                 {pwdata[`CTRL_DATA_MSB:`CTRL_DATA_LSB], 1'b1};
          st_d = pwm_config_pkg::M_BIT;
          ph_d = 2'h0;
          qcnt_d = 8'h00;
        end
      end
      pwm_config_pkg::M_STOP: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            sda_oe_d = 1'b1;
          end else if (ph_q == 2'h1) begin
            scl_oe_d = 1'b0;
          end else if (ph_q == 2'h2) begin
            sda_oe_d = 1'b0;
          end else begin
            st_d = pwm_config_pkg::M_IDLE;
          end
        end
      end
      default: begin
        st_d = pwm_config_pkg::M_IDLE;
      end
    endcase
  end

  // APB side: control readback and read data captured in the setup cycle.
  always_comb begin
    ctrl_d = wr_ctrl ? pwdata[15:0] : ctrl_q;
    prdata_d = prdata_q;
    if (psel && !penable) begin
      prdata_d = 32'h0000_0000;
      if (paddr == `CTL_REG_CTRL) begin
        prdata_d[15:0] = ctrl_q;
      end else if (paddr == `CTL_REG_STATUS) begin
        prdata_d[`STAT_BUSY_BIT] = (st_q != pwm_config_pkg::M_IDLE) &&
                                   (st_q != pwm_config_pkg::M_HOLD);
        prdata_d[`STAT_NACK_BIT] = nack_q;
        prdata_d[`STAT_OPEN_BIT] = (st_q == pwm_config_pkg::M_HOLD);
        prdata_d[`STAT_DATA_MSB:`STAT_DATA_LSB] = rdata_q;
      end
    end
  end

  // Engine and register file state.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= pwm_config_pkg::M_IDLE;
      qcnt_q <= 8'h00;
      ph_q <= 2'h0;
      bitn_q <= 4'h0;
      tx_q <= 9'h1ff;
      rx_q <= 8'h00;
      is_addr_q <= 1'b0;
      read_q <= 1'b0;
      last_q <= 1'b0;
      wbyte_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      nack_q <= 1'b0;
      rdata_q <= 8'h00;
      ctrl_q <= 16'h0000;
      prdata_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      qcnt_q <= qcnt_d;
      ph_q <= ph_d;
      bitn_q <= bitn_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      is_addr_q <= is_addr_d;
      read_q <= read_d;
      last_q <= last_d;
      wbyte_q <= wbyte_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      nack_q <= nack_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
    end
  end

  // Open-drain lines: the master only pulls low.
  assign bus.scl_m_out = 1'b0;
  assign bus.scl_m_oe = scl_oe_q;
  assign bus.sda_m_out = 1'b0;
  assign bus.sda_m_oe = sda_oe_q;
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

endmodule : pwm_config_master

/* File: sim/pwm_config_serial_slave_checker.sv */
`timescale 1ns/10ps
module pwm_config_serial_slave_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [4:0] high_cnt_q;
  logic [4:0] high_cnt_d;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // Counts how long the clock line has stood high, saturating at the top.
  always_comb begin
    high_cnt_d = 5'h00;
    if (scl) begin
      high_cnt_d = (high_cnt_q == 5'h1f) ? high_cnt_q : high_cnt_q + 5'h01;
    end
  end

  // Registers the high-time count.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      high_cnt_q <= 5'h00;
    end else begin
      high_cnt_q <= high_cnt_d;
    end
  end

  reset_quiet_a: assert property (disable iff (1'b0) !rstn |-> !sda_s_oe && !sda_m_oe && !scl_m_oe)
    else $error("a line is pulled during reset");
  dev_rise_low_a: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("device pulled data while clock high");
  dev_fall_low_a: assert property ($fell(sda_s_oe) |-> !scl)
    else $error("device released data while clock high");
  dev_hold_bit_a: assert property ($rose(sda_s_oe) |-> sda_s_oe [*8])
    else $error("device low bit too short");
  dev_quiet_idle_a: assert property (high_cnt_q > 5'h0c |-> !sda_s_oe)
    else $error("device drives data on an idle bus");
  no_clash_a: assert property (scl && sda_m_oe |-> !sda_s_oe)
    else $error("both ends pull data while clock high");
  scl_low_min_a: assert property ($fell(scl) |-> !scl [*4])
    else $error("clock low phase too short");
  scl_high_min_a: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  start_frame_a: assert property ($fell(sda) && scl |-> ##[1:20] !scl)
    else $error("no first clock after a start");

  cover property ($fell(sda) && scl);
  cover property ($rose(sda) && scl);
  cover property ($rose(sda_s_oe));
endmodule : pwm_config_serial_slave_checker

/* File: sim/pwm_config_serial_slave_bench.sv */
`timescale 1ns/10ps
`include "pwm_config_map.svh"
module pwm_config_serial_slave_bench;
  logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, chk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0] pins;
  logic [4:0] duty, m_duty;
  logic mod_out, mod_oe, shut, m_sd, m_full;
  logic [7:0] rnd;
  logic [65:0] e;
  logic [65:0] aq[$];
  logic [14:0] dq[$];
  logic [14:0] d_note;
  logic [7:0] hi;
  logic [2:0] cmds[4] = '{`CFG_CMD_DUTY, `CFG_CMD_SHUTDOWN, `CFG_CMD_RECALL, `CFG_CMD_FULL_ON};
  int n_errors, n_compared, i;
  event dev_ev;

  two_wire_if tw ();
  pwm_config_master pwm_config_master_inst (.core_clk(core_clk), .rstn(rstn),
    .bus(tw.master_end), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pwm_config_device pwm_config_device_inst (.core_clk(core_clk), .rstn(rstn),
    .bus(tw.device_end), .select_pin_bit0(pins[0]), .select_pin_bit1(pins[1]),
    .select_pin_bit2(pins[2]), .modulated_output(mod_out), .modulated_output_oe(mod_oe),
    .duty_value(duty), .shutdown_active(shut));
  pwm_config_serial_slave_checker pwm_config_serial_slave_checker_inst (.core_clk(core_clk),
    .rstn(rstn), .scl_m_oe(tw.scl_m_oe), .sda_m_oe(tw.sda_m_oe), .sda_s_oe(tw.sda_s_oe),
    .scl(tw.scl), .sda(tw.sda));

  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task bad(input string m);
    $display("BAD %0t %s", $time, m);
    n_errors++;
  endtask : bad

  task complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Marked register reads are compared with the oldest note under its mask.
  always @(posedge core_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && chk) begin
      n_compared++;
      if (aq.size() == 0) begin
        bad("no register note");
      end else begin
        e = aq.pop_front();
        if ((({pslverr, prdata} ^ e[32:0]) & e[65:33]) !== 33'h0_0000_0000) bad("register read");
      end
    end
  end

  // Device outputs are compared with the oldest note; the high time over one period follows unless the note shows shutdown.
  always @(dev_ev) begin
    if (dq.size() == 0) begin
      bad("no device note");
    end else begin
      d_note = dq.pop_front();
      n_compared++;
      if ({duty, shut, mod_oe} !== d_note[14:8]) bad("device outputs");
      hi = 8'h00;
      repeat (32 * `PWM_DIV_DEFAULT) begin
        @(posedge core_clk);
        if (mod_out === 1'b1) hi++;
      end
      if (!d_note[9]) begin
        n_compared++;
        if (hi !== d_note[7:0]) bad("modulated high time");
      end
    end
  end

  // One APB transfer; the request stands until pready is seen high or 50 cycles pass.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic c);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    chk <= c;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad("bus hang");
      complete_run();
    end
  endtask : apb

  // Reference register model of a written byte.
  task apply(input logic [7:0] d);
    case (d[7:5])
      `CFG_CMD_DUTY: begin
        m_duty = d[4:0];
        m_full = 1'b0;
      end
      `CFG_CMD_FULL_ON: m_full = 1'b1;
      `CFG_CMD_SHUTDOWN: m_sd = 1'b1;
      `CFG_CMD_RECALL: m_sd = 1'b0;
      default: ;
    endcase
  endtask : apply

  // Runs one byte through the controller, then checks status and device outputs.
  task xfer(input logic [2:0] sel, input logic rd, input logic last, input logic [7:0] d);
    int n;
    logic nk;
    logic [7:0] rb;
    logic [7:0] hx;
    nk = (sel !== pins);
    if (!rd && !nk) apply(d);
    rb = {m_sd ? `CFG_CMD_SHUTDOWN : m_full ? `CFG_CMD_FULL_ON : `CFG_CMD_DUTY, m_duty};
    hx = m_full ? 8'(32 * `PWM_DIV_DEFAULT) : 8'(m_duty * `PWM_DIV_DEFAULT);
    apb(1'b1, `CTL_REG_CTRL, {16'h0000, d, 1'b0, sel, 1'b0, last, rd, 1'b1}, 1'b0);
    n = 0;
    do begin
      apb(1'b0, `CTL_REG_STATUS, 32'h0000_0000, 1'b0);
      n++;
    end while (rdata[0] !== 1'b0 && n < 200);
    if (rdata[0] !== 1'b0) begin
      bad("transfer hang");
      complete_run();
    end else begin
      aq.push_back({1'b1, 16'h0000, (rd && !nk) ? 16'hff07 : 16'h0007,
        1'b0, 16'h0000, rb, 5'h00, !last && !nk, nk, 1'b0});
      apb(1'b0, `CTL_REG_STATUS, 32'h0000_0000, 1'b1);
      dq.push_back({m_duty, m_sd, !m_sd, hx});
      ->dev_ev;
    end
  endtask : xfer

  // Main sequence.
  initial begin
    {rstn, psel, penable, pwrite, chk, m_sd, m_full} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n_errors = 0;
    n_compared = 0;
    rnd = 8'h0a;
    pins = rnd[2:0];
    m_duty = `CFG_DUTY_RESET;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    dq.push_back({`CFG_DUTY_RESET, 1'b0, 1'b1, 8'(`CFG_DUTY_RESET * `PWM_DIV_DEFAULT)});
    ->dev_ev;
    apb(1'b1, `CTL_REG_CTRL, 32'h0000_5a70, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_ffff, 1'b0);
    aq.push_back({33'h1_ffff_ffff, 33'h1_0000_0000});
    apb(1'b0, 12'h008, 32'h0000_0000, 1'b1);
    aq.push_back({33'h1_0000_ffff, 33'h0_0000_5a70});
    apb(1'b0, `CTL_REG_CTRL, 32'h0000_0000, 1'b1);
    xfer(pins, 1'b0, 1'b1, {`CFG_CMD_DUTY, 5'h00});
    xfer(pins, 1'b1, 1'b1, 8'h00);
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      xfer(pins, 1'b0, 1'b1, {cmds[i], rnd[4:0]});
      xfer(pins, 1'b1, 1'b1, 8'h00);
    end
    xfer(pins ^ 3'h4, 1'b0, 1'b1, 8'h1f);
    xfer(pins ^ 3'h1, 1'b1, 1'b1, 8'h00);
    rnd = lfsr(rnd);
    xfer(pins, 1'b0, 1'b0, {`CFG_CMD_DUTY, rnd[4:0]});
    xfer(pins, 1'b0, 1'b1, {`CFG_CMD_SHUTDOWN, 5'h07});
    xfer(pins, 1'b1, 1'b0, 8'h00);
    xfer(pins, 1'b1, 1'b1, 8'h00);
    // Lets the last high-time count finish before the verdict.
    repeat (32 * `PWM_DIV_DEFAULT + 8) @(posedge core_clk);
    if (dq.size() != 0) bad("device note left over");
    complete_run();
  end
endmodule : pwm_config_serial_slave_bench
